// *** hw/supply_prot_pkg.sv ***
// constants for the supply protection and status register bank
//Contract
//- bit0 enables current diagnostic; bit0 only drives o_current_diag_enable, not o_output_enable
//- overload latch bit3 clears level select
//- bit3 clear: output recovers, selection kept
//- overheat latch bit6 clears level select
//- bit6 clear: output recovers, selection kept
//- bit7 selects high or low ESR compensation
//- status registers read only, writes ignored
//- status bit0 shows overload active
//- status bit2 shows output voltage low
//- status bit4 shows deglitched pulldown overcurrent
//- status bit6 overheat with 150/135 hysteresis
//- status bit7 shows input supply low
//- registers cleared to zero at reset
//- level select in bits 0-3 at 0x2
//- read/write register reads last written byte masked to its defined bits
//- reads continue to next register while acked
package supply_prot_pkg;
	localparam logic [7:0] addr_status_one    = 8'h00;
	localparam logic [7:0] addr_status_two    = 8'h01;
	localparam logic [7:0] addr_level_select  = 8'h02;
	localparam logic [7:0] addr_prot_config   = 8'h05;
	localparam logic [7:0] reset_byte         = 8'h00;
	localparam logic [7:0] level_select_mask  = 8'h0f;
	localparam logic [7:0] prot_config_mask   = 8'hc9;
	localparam int         bit_diag_enable    = 0;
	localparam int         bit_overload_latch = 3;
	localparam int         bit_overheat_latch = 6;
	localparam int         bit_high_esr       = 7;
	localparam int         bit_overload       = 0;
	localparam int         bit_vout_low       = 2;
	localparam int         bit_pulldown_oc    = 4;
	localparam int         bit_overheat       = 6;
	localparam int         bit_supply_low     = 7;
	localparam int         clk_mhz            = 125;
	localparam int         deglitch_ns        = 10000;
	localparam int         deglitch_cycles    = deglitch_ns * clk_mhz / 1000;
	localparam int         deglitch_width     = 11;
	localparam logic [deglitch_width-1:0] deglitch_last =
		deglitch_width'(deglitch_cycles - 1);
endpackage : supply_prot_pkg

// *** hw/supply_protection_status_regs.sv ***
// protection configuration and diagnostic status register bank
`timescale 1ns/10ps
module supply_protection_status_regs (
	input  wire logic       i_sys_clk,
	input  wire logic       i_reset,
	input  wire logic [7:0] i_reg_addr,
	input  wire logic       i_wr_strobe,
	input  wire logic [7:0] i_wr_data,
	input  wire logic       i_rd_start,
	input  wire logic       i_rd_next,
	output logic      [7:0] o_rd_data,
	input  wire logic       i_overload_raw,
	input  wire logic       i_vout_low_raw,
	input  wire logic       i_pulldown_oc_raw,
	input  wire logic       i_temp_above_150,
	input  wire logic       i_temp_below_135,
	input  wire logic       i_supply_low_raw,
	output logic      [3:0] o_output_level_select,
	output logic            o_output_enable,
	output logic            o_current_diag_enable,
	output logic            o_high_esr_comp
);
	import supply_prot_pkg::*;

	typedef struct packed {
		logic [5:0]                sync_a;
		logic [5:0]                sync_b;
		logic [deglitch_width-1:0] pd_count;
		logic                      pulldown_oc_flag;
		logic                      overheat_flag;
		logic [7:0]                level_select;
		logic [7:0]                prot_config;
		logic [7:0]                rd_ptr;
		logic [7:0]                rd_data;
	} state_t;

	state_t state;
	state_t next_state;
	logic   overload_flag;
	logic   output_voltage_low_flag;
	logic   input_supply_low_flag;
	logic   pd_raw;
	logic   hot_above;
	logic   cool_below;
	logic [7:0] status_one;
	logic [7:0] rd_addr;

	function automatic logic [7:0] read_byte(input logic [7:0] a,
		input logic [7:0] st, input logic [7:0] lv, input logic [7:0] pc);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			addr_status_one:   r = st;
			addr_level_select: r = lv & level_select_mask;
			addr_prot_config:  r = pc & prot_config_mask;
			default:           r = 8'h00;
		endcase
		return r;
	endfunction : read_byte

	always_comb begin
		overload_flag           = state.sync_b[0];
		output_voltage_low_flag = state.sync_b[1];
		pd_raw                  = state.sync_b[2];
		hot_above               = state.sync_b[3];
		cool_below              = state.sync_b[4];
		input_supply_low_flag   = state.sync_b[5];
		status_one = 8'h00;
		status_one[bit_overload]    = overload_flag;
		status_one[bit_vout_low]    = output_voltage_low_flag;
		status_one[bit_pulldown_oc] = state.pulldown_oc_flag;
		status_one[bit_overheat]    = state.overheat_flag;
		status_one[bit_supply_low]  = input_supply_low_flag;
		rd_addr = i_rd_start ? i_reg_addr : 8'(state.rd_ptr + 8'h01);
	end

	always_comb begin
		next_state = state;
		next_state.sync_a = {i_supply_low_raw, i_temp_below_135,
			i_temp_above_150, i_pulldown_oc_raw, i_vout_low_raw,
			i_overload_raw};
		next_state.sync_b = state.sync_a;
		// pulldown overcurrent deglitch
		if (!pd_raw) begin
			next_state.pd_count         = '0;
			next_state.pulldown_oc_flag = 1'b0;
		end else if (state.pd_count == deglitch_last) begin
			next_state.pulldown_oc_flag = 1'b1;
		end else begin
			next_state.pd_count = state.pd_count + 1'b1;
		end
		// thermal hysteresis
		if (hot_above)
			next_state.overheat_flag = 1'b1;
		else if (cool_below)
			next_state.overheat_flag = 1'b0;
		// writes; status addresses are not writable
		if (i_wr_strobe) begin
			if (i_reg_addr == addr_level_select)
				next_state.level_select = i_wr_data & level_select_mask;
			else if (i_reg_addr == addr_prot_config)
				next_state.prot_config = i_wr_data & prot_config_mask;
		end
		// latched protection clears the selection while the fault stands
		if (overload_flag && state.prot_config[bit_overload_latch])
			next_state.level_select = 8'h00;
		if (state.overheat_flag && state.prot_config[bit_overheat_latch])
			next_state.level_select = 8'h00;
		// read pointer with auto increment
		if (i_rd_start || i_rd_next) begin
			next_state.rd_ptr  = rd_addr;
			next_state.rd_data = read_byte(rd_addr, status_one,
				state.level_select, state.prot_config);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			state              <= '0;
			state.level_select <= reset_byte;
			state.prot_config  <= reset_byte;
		end else begin
			state <= next_state;
		end
	end

	assign o_rd_data             = state.rd_data;
	assign o_output_level_select = state.level_select[3:0];
	// non-latched mode: output returns with kept selection
	assign o_output_enable = (state.level_select[3:0] != 4'h0)
		&& !overload_flag && !state.overheat_flag;
	assign o_current_diag_enable = state.prot_config[bit_diag_enable];
	assign o_high_esr_comp       = state.prot_config[bit_high_esr];
endmodule : supply_protection_status_regs

// *** dv/supply_prot_sva.sv ***
// port assertions for the register bank
`timescale 1ns/10ps
module supply_prot_sva (
	input wire logic i_sys_clk, i_reset, i_wr_strobe, i_rd_start, i_rd_next,
	input wire logic [7:0] i_reg_addr, i_wr_data, o_rd_data,
	input wire logic i_overload_raw, i_vout_low_raw, i_pulldown_oc_raw,
	input wire logic i_temp_above_150, i_temp_below_135, i_supply_low_raw,
	input wire logic [3:0] o_output_level_select,
	input wire logic o_output_enable, o_current_diag_enable, o_high_esr_comp
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	sequence rd_stat; i_rd_start && i_reg_addr == 8'h00; endsequence
	sequence cfg_wr; i_wr_strobe && i_reg_addr == 8'h05; endsequence
	a_diag_bit: assert property (cfg_wr |=>
		o_current_diag_enable == $past(i_wr_data[0])) else $error("diag bit");
	a_esr_bit: assert property (cfg_wr |=>
		o_high_esr_comp == $past(i_wr_data[7])) else $error("esr bit");
	a_overload_off: assert property (i_overload_raw [*5] |->
		!o_output_enable) else $error("output on in overload");
	a_cfg_read: assert property (i_rd_start && i_reg_addr == 8'h05 |=>
		(o_rd_data & 8'h37) == {7'h00, o_current_diag_enable})
		else $error("config read");
	a_overload_flag: assert property (i_overload_raw [*5] ##0 rd_stat |=>
		o_rd_data[0]) else $error("overload flag");
	a_flag_live: assert property ((!i_overload_raw) [*5] ##0 rd_stat |=>
		!o_rd_data[0]) else $error("overload flag sticky");
	a_pulldown_low: assert property ((!i_pulldown_oc_raw) [*5] ##0 rd_stat |=>
		!o_rd_data[4]) else $error("pulldown flag");
	a_read_hold: assert property (!i_rd_start && !i_rd_next |=>
		$stable(o_rd_data)) else $error("read data moved");
endmodule : supply_prot_sva
bind supply_protection_status_regs supply_prot_sva chk (.*);

// *** dv/serial_master_model.sv ***
// bus master model issuing register accesses
`timescale 1ns/10ps
module serial_master_model (
	input  wire logic       i_sys_clk,
	input  wire logic [7:0] i_rd_data,
	output logic      [7:0] o_addr, o_data,
	output logic            o_wr, o_rd, o_nx
);
	initial begin
		{o_addr, o_data, o_wr, o_rd, o_nx} = '0;
	end
	task automatic xfer(input logic [2:0] k, input logic [7:0] a, d,
		output logic [7:0] q);
		@(posedge i_sys_clk);
		{o_addr, o_data, o_wr, o_rd, o_nx} <= {a, d, k};
		@(posedge i_sys_clk);
		{o_addr, o_data, o_wr, o_rd, o_nx} <= {~a, ~d, 3'b000};
		#1 q = i_rd_data;
	endtask : xfer
endmodule : serial_master_model

// *** dv/tb_top.sv ***
// self-checking bench for the register bank
`timescale 1ns/10ps
module tb_top;
	import supply_prot_pkg::*;
	logic clk = 0, rst = 1, ovl = 0, vl = 0, pd = 0, hi = 0, lo = 0, sl = 0;
	logic [7:0] a, d, q;
	logic       w, r, n, en, dg, esr;
	logic [3:0] lv;
	int         num_errors = 0, tests_run = 0;
	always #4 clk = ~clk;
	serial_master_model m (.i_sys_clk(clk), .i_rd_data(q), .o_addr(a),
		.o_data(d), .o_wr(w), .o_rd(r), .o_nx(n));
	supply_protection_status_regs dut (.i_sys_clk(clk), .i_reset(rst),
		.i_reg_addr(a), .i_wr_strobe(w), .i_wr_data(d), .i_rd_start(r),
		.i_rd_next(n), .o_rd_data(q), .i_overload_raw(ovl),
		.i_vout_low_raw(vl), .i_pulldown_oc_raw(pd), .i_temp_above_150(hi),
		.i_temp_below_135(lo), .i_supply_low_raw(sl),
		.o_output_level_select(lv), .o_output_enable(en),
		.o_current_diag_enable(dg), .o_high_esr_comp(esr));
	task automatic chk(input string nm, input logic [7:0] s, e);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] ad, dt);
		logic [7:0] x;
		m.xfer(3'b100, ad, dt, x);
	endtask : wr
	task automatic rd(input logic [2:0] k, input logic [7:0] ad, e);
		logic [7:0] x;
		m.xfer(k, ad, 8'h00, x);
		chk("read", x, e);
	endtask : rd
	task automatic trip(input logic [7:0] cfg, input logic s, lat);
		wr(8'h05, cfg);
		wr(8'h02, 8'h03);
		@(posedge clk) {hi, ovl} <= {s, !s};
		repeat (6) @(posedge clk);
		chk("enable", en, 8'h00);
		rd(3'b010, 8'h00, s ? 8'h40 : 8'h01);
		@(posedge clk) {hi, ovl} <= 2'b00;
		repeat (6) @(posedge clk);
		rd(3'b010, 8'h00, s ? 8'h40 : 8'h00);
		@(posedge clk) lo <= 1;
		repeat (6) @(posedge clk);
		chk("level", lv, lat ? 8'h00 : 8'h03);
		wr(8'h02, 8'h03);
		chk("enable", en, 8'h01);
		@(posedge clk) lo <= 0;
		$display("test protection %h done", cfg);
	endtask : trip
	task automatic give_verdict();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (20) @(posedge clk);
		rst <= 0;
		rd(3'b010, 8'h05, 8'h00);
		rd(3'b010, 8'h00, 8'h00);
		wr(8'h05, 8'hff);
		chk("diag esr", {dg, esr}, 8'h03);
		rd(3'b010, 8'h05, 8'hc9);
		wr(8'h02, 8'h13);
		chk("level", lv, 8'h03);
		wr(8'h00, 8'hff);
		rd(3'b010, 8'h00, 8'h00);
		rd(3'b010, 8'h04, 8'h00);
		rd(3'b001, 8'h00, 8'hc9);
		$display("test registers done");
		trip(8'h08, 0, 1);
		trip(8'h00, 0, 0);
		trip(8'h40, 1, 1);
		trip(8'h00, 1, 0);
		@(posedge clk) {vl, sl, pd} <= 3'b111;
		repeat (100) @(posedge clk);
		rd(3'b010, 8'h00, 8'h84);
		repeat (deglitch_cycles) @(posedge clk);
		rd(3'b010, 8'h00, 8'h94);
		$display("test status done");
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		give_verdict();
	end
endmodule : tb_top
